// ==== slrsi_pkg.sv ====
// register map, field positions and reset values of the link status and interrupt block
package slrsi_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_INIT_LANE_SYNC_STATUS  = 12'h473;
  localparam logic [11:0] OFF_OCTETS_PER_FRAME_CFG   = 12'h476;
  localparam logic [11:0] OFF_LINK_TEST_CONTROL      = 12'h477;
  localparam logic [11:0] OFF_ALIGN_MULTIFRAME_COUNT = 12'h478;
  localparam logic [11:0] OFF_LINK_INTERRUPT_VECTOR  = 12'h47A;
  localparam logic [11:0] OFF_SYNC_ASSERTION_MASK    = 12'h47B;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned BIT_STATUS_IRQ_CLEAR  = 7;
  localparam int unsigned BIT_TEST_MODE         = 7;
  localparam int unsigned BIT_THRESH_MASK_EN    = 3;
  localparam int unsigned BIT_VEC_DISPARITY     = 7;
  localparam int unsigned BIT_VEC_INVALID_SYM   = 6;
  localparam int unsigned BIT_VEC_STRAY_CTRL    = 5;
  localparam int unsigned BIT_VEC_RESERVED      = 4;
  localparam int unsigned BIT_VEC_ALIGN_FAIL    = 3;
  localparam int unsigned BIT_SYNC_DISPARITY    = 7;
  localparam int unsigned BIT_SYNC_INVALID_SYM  = 6;
  localparam int unsigned BIT_SYNC_STRAY_CTRL   = 5;

  // ------------------------------------------------------------------
  // reset values and widths
  // ------------------------------------------------------------------
  localparam int unsigned LANE_MAX                  = 8;
  localparam logic [7:0]  RST_INIT_LANE_SYNC_STATUS = 8'h00;
  localparam logic [7:0]  RST_OCTETS_PER_FRAME      = 8'h01;
  localparam logic [7:0]  RST_LINK_TEST_CONTROL     = 8'h00;
  localparam logic [7:0]  RST_ALIGN_MULTIFRAME      = 8'h01;
  localparam logic [7:0]  RST_INTERRUPT_MASK        = 8'h00;
  localparam logic [7:0]  RST_SYNC_ASSERTION_MASK   = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED             = 8'h00;

endpackage : slrsi_pkg

// ==== slrsi_sticky.sv ====
// sticky flag bank: hardware set wins over a software clear in the same cycle
`timescale 1ns/100ps
module slrsi_sticky #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,     // device clock
  input  wire logic         rst_n,   // synchronous reset, active low
  input  wire logic [W-1:0] setBits, // event pulses that raise flags
  input  wire logic [W-1:0] clrBits, // software clear pulses
  output logic      [W-1:0] flags_q  // held flags
);

  logic [W-1:0] flags_d;

  always_comb begin
    flags_d = (flags_q & ~clrBits) | setBits;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : slrsi_sticky

// ==== slrsi_lane_loss.sv ====
// per-lane detector of a lost alignment: a one-cycle pulse when a lane's ok bit falls
`timescale 1ns/100ps
module slrsi_lane_loss #(
  parameter int unsigned LANES = 8
) (
  input  wire logic             clk,        // device clock
  input  wire logic             rst_n,      // synchronous reset, active low
  input  wire logic [LANES-1:0] laneOk,     // live alignment status per lane
  output logic      [LANES-1:0] lossPulse_q // one-cycle loss pulse per lane
);

  logic [LANES-1:0] prevOk_q;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        prevOk_q[i]    <= 1'b0;
        lossPulse_q[i] <= 1'b0;
      end else begin
        prevOk_q[i]    <= laneOk[i];
        lossPulse_q[i] <= prevOk_q[i] & ~laneOk[i];
      end
    end
  end

endmodule : slrsi_lane_loss

// ==== slrsi_top.sv ====
// link receiver status, configuration and interrupt vector with its register port
// What this block does
// RULE_01: eight-bit per-lane alignment success status, one bit per lane, resets to zero.
// RULE_02: writing one to status bit 7 clears the pending alignment-fail interrupt.
// RULE_03: lost lane alignment also drives the sync request output toward the transmitter.
// RULE_04: software writes only 1, 2 or 4 to octets per frame; reset one.
// RULE_05: test mode bit 7 set keeps receiver accepting alignment frames; clear is normal.
// RULE_06: software sets threshold mask enable bit 3 when using sync assertion mask.
// RULE_07: multiframe count, reset one, sets alignment length in units of 4xK multiframes.
// RULE_08: vector bit 7 reads one when disparity errors reached threshold on a lane.
// RULE_09: disparity mask bit 7 set pulls interrupt low on disparity threshold.
// RULE_10: vector bit 6 reads one when invalid-symbol errors reached threshold on a lane.
// RULE_11: invalid-symbol mask bit 6 set pulls interrupt low on that threshold.
// RULE_12: vector bit 5 reads one when stray control characters reached threshold.
// RULE_13: stray control mask bit 5 set pulls interrupt low on that threshold.
// RULE_14: alignment-fail mask bit 3 set pulls interrupt low when any lane fails.
// RULE_15: vector bit 3 reads one after an alignment failure; bit 4 reads zero.
// RULE_16: vector reads give flags, writes set only masks; masks reset zero, interrupt high.
// RULE_17: disparity sync enable set raises sync request on disparity threshold.
`timescale 1ns/100ps
module slrsi_top #(
  parameter int unsigned LANES = 8
) (
  input  wire logic             clk,                  // device clock, 200 MHz
  input  wire logic             rst_n,                // synchronous reset, active low
  input  wire logic             regWrEn,              // register write strobe
  input  wire logic             regRdEn,              // register read strobe
  input  wire logic [11:0]      regAddr,              // register address
  input  wire logic [7:0]       regWrData,            // register write data
  output logic      [7:0]       regRdData_q,          // register read data
  output logic                  regRdValid_q,         // read data valid pulse
  input  wire logic [LANES-1:0] laneAlignOk,          // per-lane alignment ok level
  input  wire logic [LANES-1:0] laneDisparityHit,     // per-lane disparity threshold reached
  input  wire logic [LANES-1:0] laneInvalidHit,       // per-lane invalid symbol threshold
  input  wire logic [LANES-1:0] laneStrayHit,         // per-lane stray control threshold
  output logic      [7:0]       octetsPerFrame_q,     // octets per frame setting
  output logic      [7:0]       alignMultiframeCnt_q, // alignment length, 4xK units
  output logic                  alignmentTestMode_q,  // keep accepting alignment frames
  output logic                  thresholdMaskEn_q,    // threshold mask enable
  output logic                  syncRequestOutN_q,    // sync request, active low
  output logic                  irqN_q                // interrupt, active low
);
  default clocking cbDev @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // decoding and lane usage
  // ------------------------------------------------------------------
  localparam logic [7:0] LANE_USED = 8'((9'h001 << LANES) - 9'h001);

  function automatic logic addrHit(input logic [11:0] a, input logic [11:0] off);
    addrHit = (a == off);
  endfunction : addrHit

  logic [7:0] laneOkPad, laneLossPad;
  logic [LANES-1:0] lossPulse;
  always_comb begin
    laneOkPad = '0;
    laneOkPad[LANES-1:0] = laneAlignOk;
    laneLossPad = '0;
    laneLossPad[LANES-1:0] = lossPulse;
  end

  logic wrStatus, wrOctets, wrTest, wrMultiframe, wrVector, wrSyncMask;
  always_comb begin
    wrStatus     = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_INIT_LANE_SYNC_STATUS);
    wrOctets     = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_OCTETS_PER_FRAME_CFG);
    wrTest       = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_LINK_TEST_CONTROL);
    wrMultiframe = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_ALIGN_MULTIFRAME_COUNT);
    wrVector     = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_LINK_INTERRUPT_VECTOR);
    wrSyncMask   = regWrEn && addrHit(regAddr, slrsi_pkg::OFF_SYNC_ASSERTION_MASK);
  end

  // ------------------------------------------------------------------
  // lane alignment status
  // ------------------------------------------------------------------
  logic [7:0] laneAlignOkBits_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      laneAlignOkBits_q <= slrsi_pkg::RST_INIT_LANE_SYNC_STATUS; // [RULE_01]
    end else begin
      laneAlignOkBits_q <= laneOkPad & LANE_USED; // [RULE_01]
    end
  end

  slrsi_lane_loss #(
    .LANES (LANES)
  ) u_lane_loss (
    .clk         (clk),
    .rst_n       (rst_n),
    .laneOk      (laneAlignOk),
    .lossPulse_q (lossPulse)
  );

  logic alignFailSet;
  logic alignFailClr;
  logic laneAlignFailFlag;
  always_comb begin
    alignFailSet = |(laneLossPad & LANE_USED);
    alignFailClr = wrStatus && regWrData[slrsi_pkg::BIT_STATUS_IRQ_CLEAR]; // [RULE_02]
  end

  slrsi_sticky #(
    .W (1)
  ) u_align_fail (
    .clk     (clk),
    .rst_n   (rst_n),
    .setBits (alignFailSet),
    .clrBits (alignFailClr),
    .flags_q (laneAlignFailFlag)
  );

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      octetsPerFrame_q <= slrsi_pkg::RST_OCTETS_PER_FRAME;
    end else if (wrOctets) begin
      octetsPerFrame_q <= regWrData; // [RULE_04]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alignmentTestMode_q <= slrsi_pkg::RST_LINK_TEST_CONTROL[slrsi_pkg::BIT_TEST_MODE];
      thresholdMaskEn_q   <= slrsi_pkg::RST_LINK_TEST_CONTROL[slrsi_pkg::BIT_THRESH_MASK_EN];
    end else if (wrTest) begin
      alignmentTestMode_q <= regWrData[slrsi_pkg::BIT_TEST_MODE]; // [RULE_05]
      thresholdMaskEn_q   <= regWrData[slrsi_pkg::BIT_THRESH_MASK_EN]; // [RULE_06]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alignMultiframeCnt_q <= slrsi_pkg::RST_ALIGN_MULTIFRAME; // [RULE_07]
    end else if (wrMultiframe) begin
      alignMultiframeCnt_q <= regWrData; // [RULE_07]
    end
  end

  logic [7:0] syncAssertMask_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncAssertMask_q <= slrsi_pkg::RST_SYNC_ASSERTION_MASK;
    end else if (wrSyncMask) begin
      syncAssertMask_q <= regWrData & 8'hE0;
    end
  end

  // ------------------------------------------------------------------
  // interrupt vector: flags and write-only masks
  // ------------------------------------------------------------------
  logic disparityErrorFlag_q, invalidSymbolFlag_q, strayControlCharFlag_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disparityErrorFlag_q   <= 1'b0;
      invalidSymbolFlag_q    <= 1'b0;
      strayControlCharFlag_q <= 1'b0;
    end else begin
      disparityErrorFlag_q   <= |laneDisparityHit; // [RULE_08]
      invalidSymbolFlag_q    <= |laneInvalidHit; // [RULE_10]
      strayControlCharFlag_q <= |laneStrayHit; // [RULE_12]
    end
  end

  logic [7:0] vectorFlags;
  always_comb begin
    vectorFlags = '0;
    vectorFlags[slrsi_pkg::BIT_VEC_DISPARITY]   = disparityErrorFlag_q;
    vectorFlags[slrsi_pkg::BIT_VEC_INVALID_SYM] = invalidSymbolFlag_q;
    vectorFlags[slrsi_pkg::BIT_VEC_STRAY_CTRL]  = strayControlCharFlag_q;
    vectorFlags[slrsi_pkg::BIT_VEC_RESERVED]    = 1'b0; // [RULE_15]
    vectorFlags[slrsi_pkg::BIT_VEC_ALIGN_FAIL]  = laneAlignFailFlag; // [RULE_15]
  end

  logic [7:0] irqMask_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqMask_q <= slrsi_pkg::RST_INTERRUPT_MASK; // [RULE_16]
    end else if (wrVector) begin
      irqMask_q <= regWrData & 8'hE8; // [RULE_16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqN_q <= 1'b1; // [RULE_16]
    end else begin
      irqN_q <= ~|(vectorFlags & irqMask_q); // [RULE_09] [RULE_11] [RULE_13] [RULE_14]
    end
  end

  // ------------------------------------------------------------------
  // sync request toward the transmitter
  // ------------------------------------------------------------------
  logic anyLaneDown;
  logic thresholdSyncReq;
  always_comb begin
    anyLaneDown      = |(~laneOkPad & LANE_USED);
    thresholdSyncReq = (syncAssertMask_q[slrsi_pkg::BIT_SYNC_DISPARITY] & disparityErrorFlag_q)
                     | (syncAssertMask_q[slrsi_pkg::BIT_SYNC_INVALID_SYM] & invalidSymbolFlag_q)
                     | (syncAssertMask_q[slrsi_pkg::BIT_SYNC_STRAY_CTRL] & strayControlCharFlag_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncRequestOutN_q <= 1'b1;
    end else begin
      syncRequestOutN_q <= ~(anyLaneDown | thresholdSyncReq); // [RULE_03] [RULE_17]
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    rdMux = slrsi_pkg::READ_UNMAPPED;
    if (addrHit(regAddr, slrsi_pkg::OFF_INIT_LANE_SYNC_STATUS)) begin
      rdMux = laneAlignOkBits_q;
    end else if (addrHit(regAddr, slrsi_pkg::OFF_OCTETS_PER_FRAME_CFG)) begin
      rdMux = octetsPerFrame_q;
    end else if (addrHit(regAddr, slrsi_pkg::OFF_LINK_TEST_CONTROL)) begin
      rdMux = '0;
      rdMux[slrsi_pkg::BIT_TEST_MODE]      = alignmentTestMode_q;
      rdMux[slrsi_pkg::BIT_THRESH_MASK_EN] = thresholdMaskEn_q;
    end else if (addrHit(regAddr, slrsi_pkg::OFF_ALIGN_MULTIFRAME_COUNT)) begin
      rdMux = alignMultiframeCnt_q;
    end else if (addrHit(regAddr, slrsi_pkg::OFF_LINK_INTERRUPT_VECTOR)) begin
      rdMux = vectorFlags; // [RULE_16]
    end else if (addrHit(regAddr, slrsi_pkg::OFF_SYNC_ASSERTION_MASK)) begin
      rdMux = syncAssertMask_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData_q  <= '0;
      regRdValid_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
      if (regRdEn) begin
        regRdData_q <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_vecWrite(int unsigned b);
    wrVector && regWrData[b];
  endsequence
  sequence s_failRaised;
    alignFailSet && !alignFailClr;
  endsequence

  property p_statusTracksLanes;
    1'b1 |=> laneAlignOkBits_q == ($past(laneOkPad) & LANE_USED);
  endproperty
  a_statusTracksLanes: assert property (p_statusTracksLanes) // [RULE_01]
    else $error("status does not follow lane ok bits");
  property p_clearWinsOnlyWithoutSet;
    (alignFailClr && !alignFailSet) |=> !laneAlignFailFlag;
  endproperty
  a_clearWinsOnlyWithoutSet: assert property (p_clearWinsOnlyWithoutSet) // [RULE_02]
    else $error("alignment fail flag not cleared by write");
  property p_failSetHolds;
    s_failRaised |=> laneAlignFailFlag && vectorFlags[slrsi_pkg::BIT_VEC_ALIGN_FAIL];
  endproperty
  a_failSetHolds: assert property (p_failSetHolds) // [RULE_15]
    else $error("alignment fail flag not raised");
  property p_syncOnLaneDown;
    anyLaneDown |=> !syncRequestOutN_q;
  endproperty
  a_syncOnLaneDown: assert property (p_syncOnLaneDown) // [RULE_03]
    else $error("sync request missing on lane loss");
  property p_testModeWrite;
    wrTest |=> alignmentTestMode_q == $past(regWrData[slrsi_pkg::BIT_TEST_MODE]);
  endproperty
  a_testModeWrite: assert property (p_testModeWrite) // [RULE_05]
    else $error("test mode not taken from write");
  property p_multiframeStable;
    !wrMultiframe |=> $stable(alignMultiframeCnt_q);
  endproperty
  a_multiframeStable: assert property (p_multiframeStable) // [RULE_07]
    else $error("multiframe count changed without write");
  property p_disparityIrq;
    (laneDisparityHit != '0) ##1 irqMask_q[slrsi_pkg::BIT_VEC_DISPARITY] |=> !irqN_q;
  endproperty
  a_disparityIrq: assert property (p_disparityIrq) // [RULE_08] [RULE_09]
    else $error("disparity threshold did not pull interrupt low");
  property p_invalidIrq;
    (laneInvalidHit != '0) ##1 irqMask_q[slrsi_pkg::BIT_VEC_INVALID_SYM] |=> !irqN_q;
  endproperty
  a_invalidIrq: assert property (p_invalidIrq) // [RULE_10] [RULE_11]
    else $error("invalid symbol threshold did not pull interrupt low");
  property p_strayIrq;
    (laneStrayHit != '0) ##1 irqMask_q[slrsi_pkg::BIT_VEC_STRAY_CTRL] |=> !irqN_q;
  endproperty
  a_strayIrq: assert property (p_strayIrq) // [RULE_12] [RULE_13]
    else $error("stray control threshold did not pull interrupt low");
  property p_failIrq;
    (laneAlignFailFlag && irqMask_q[slrsi_pkg::BIT_VEC_ALIGN_FAIL]) |=> !irqN_q;
  endproperty
  a_failIrq: assert property (p_failIrq) // [RULE_14]
    else $error("alignment failure did not pull interrupt low");
  property p_maskWriteOnly;
    s_vecWrite(slrsi_pkg::BIT_VEC_DISPARITY) |=> irqMask_q[slrsi_pkg::BIT_VEC_DISPARITY]
      && (vectorFlags[slrsi_pkg::BIT_VEC_DISPARITY] == disparityErrorFlag_q);
  endproperty
  a_maskWriteOnly: assert property (p_maskWriteOnly) // [RULE_16]
    else $error("vector write did not land in mask");
  property p_irqHighWithoutCause;
    ((vectorFlags & irqMask_q) == '0) |=> irqN_q;
  endproperty
  a_irqHighWithoutCause: assert property (p_irqHighWithoutCause) // [RULE_16]
    else $error("interrupt low without unmasked flag");
  property p_disparitySync;
    (syncAssertMask_q[slrsi_pkg::BIT_SYNC_DISPARITY] && disparityErrorFlag_q)
      |=> !syncRequestOutN_q;
  endproperty
  a_disparitySync: assert property (p_disparitySync) // [RULE_17]
    else $error("disparity threshold did not request sync");
  property p_reservedZero;
    regRdValid_q && $past(addrHit(regAddr, slrsi_pkg::OFF_LINK_INTERRUPT_VECTOR))
      |-> regRdData_q[slrsi_pkg::BIT_VEC_RESERVED] == 1'b0;
  endproperty
  a_reservedZero: assert property (p_reservedZero) // [RULE_15]
    else $error("reserved vector bit read as one");

endmodule : slrsi_top

// ==== slrsi_tx_model.sv ====
// behavioural transmitter: drops lanes on command, realigns after a sync request
`timescale 1ns/100ps
module slrsi_tx_model (
  input  wire logic       clk,       // device clock
  input  wire logic       rst_n,     // synchronous reset, active low
  input  wire logic       syncReqN,  // sync request from the receiver, active low
  input  wire logic [7:0] kCnt,      // multiframe count setting
  input  wire logic [7:0] dropLanes, // lanes to knock out of alignment
  output logic      [7:0] laneOk     // alignment ok level per lane
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      laneOk <= 8'h00;
      cnt_q  <= 8'h00;
    end else if (dropLanes != 8'h00) begin
      laneOk <= laneOk & ~dropLanes;
      cnt_q  <= 8'h00;
    end else if (!syncReqN) begin // answer a sync request with a new alignment
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q >= {kCnt[5:0], 2'b00}) begin // alignment lasts 4xK units
        laneOk <= 8'hFF;
      end
    end else begin
      cnt_q <= 8'h00;
    end
  end
endmodule : slrsi_tx_model

// ==== slrsi_top_tb.sv ====
// self-checking bench for the link status and interrupt block
`timescale 1ns/100ps
module slrsi_top_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWrData = 8'h00;
  logic [7:0]  regRdData_q;
  logic        regRdValid_q;
  logic [7:0]  laneAlignOk;
  logic [7:0]  dispHit = 8'h00;
  logic [7:0]  invHit = 8'h00;
  logic [7:0]  strayHit = 8'h00;
  logic [7:0]  dropLanes = 8'h00;
  logic [7:0]  octetsPerFrame_q;
  logic [7:0]  alignMultiframeCnt_q;
  logic        alignmentTestMode_q;
  logic        thresholdMaskEn_q;
  logic        syncRequestOutN_q;
  logic        irqN_q;
  logic [7:0]  d;
  int          n_errors = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  slrsi_top i_dut (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .laneAlignOk(laneAlignOk), .laneDisparityHit(dispHit),
    .laneInvalidHit(invHit), .laneStrayHit(strayHit), .octetsPerFrame_q(octetsPerFrame_q),
    .alignMultiframeCnt_q(alignMultiframeCnt_q), .alignmentTestMode_q(alignmentTestMode_q),
    .thresholdMaskEn_q(thresholdMaskEn_q), .syncRequestOutN_q(syncRequestOutN_q),
    .irqN_q(irqN_q));

  slrsi_tx_model i_tx (.clk(clk), .rst_n(rst_n), .syncReqN(syncRequestOutN_q),
    .kCnt(alignMultiframeCnt_q), .dropLanes(dropLanes), .laneOk(laneAlignOk));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(negedge clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
    chk({7'h00, regRdValid_q}, 8'h01, "read valid");
    v = regRdData_q;
  endtask : rd

  task automatic wait_sync();
    for (int i = 0; i < 200 && syncRequestOutN_q !== 1'b1; i++) @(negedge clk);
    chk({7'h00, syncRequestOutN_q}, 8'h01, "sync released");
  endtask : wait_sync

  task automatic t_reset();
    logic [11:0] a [7] = '{12'h473, 12'h476, 12'h477, 12'h478, 12'h47A, 12'h47B, 12'h470};
    logic [7:0]  e [7] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    chk({7'h00, syncRequestOutN_q}, 8'h00, "sync after reset");
    chk({7'h00, irqN_q}, 8'h01, "irq idle");
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      chk(d, e[i], "reset value");
    end
    wait_sync();
    rd(12'h473, d);
    chk(d, 8'hFF, "status aligned");
    $display("test reset done");
  endtask : t_reset

  task automatic t_config();
    for (int i = 0; i < 3; i++) begin
      wr(12'h476, 8'h01 << i);
      rd(12'h476, d);
      chk(d, 8'h01 << i, "octets read");
      chk(octetsPerFrame_q, 8'h01 << i, "octets port");
    end
    wr(12'h477, 8'hFF);
    rd(12'h477, d);
    chk(d, 8'h88, "test control");
    chk({6'h00, alignmentTestMode_q, thresholdMaskEn_q}, 8'h03, "mode on");
    wr(12'h477, 8'h08);
    chk({6'h00, alignmentTestMode_q, thresholdMaskEn_q}, 8'h01, "mode off");
    wr(12'h478, 8'h03);
    rd(12'h478, d);
    chk(d, 8'h03, "multiframe read");
    chk(alignMultiframeCnt_q, 8'h03, "multiframe port");
    wr(12'h470, 8'hFF);
    rd(12'h470, d);
    chk(d, 8'h00, "unmapped");
    $display("test config done");
  endtask : t_config

  task automatic t_flags();
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      b = 8'h80 >> i;
      wr(12'h47A, 8'hE8 & ~b);
      dispHit = (i == 0) ? 8'h10 : 8'h00;
      invHit = (i == 1) ? 8'h02 : 8'h00;
      strayHit = (i == 2) ? 8'h80 : 8'h00;
      repeat (3) @(negedge clk);
      rd(12'h47A, d);
      chk(d, b, "vector flag");
      chk({7'h00, irqN_q}, 8'h01, "irq masked");
      wr(12'h47A, b);
      repeat (2) @(negedge clk);
      chk({7'h00, irqN_q}, 8'h00, "irq raised");
      dispHit = 8'h00;
      invHit = 8'h00;
      strayHit = 8'h00;
      repeat (3) @(negedge clk);
      chk({7'h00, irqN_q}, 8'h01, "irq dropped");
    end
    wr(12'h47A, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_align();
    wr(12'h47A, 8'h08);
    dropLanes = 8'h04;
    @(negedge clk);
    dropLanes = 8'h00;
    rd(12'h473, d);
    chk(d, 8'hFB, "status lost lane");
    chk({7'h00, syncRequestOutN_q}, 8'h00, "sync on loss");
    @(negedge clk);
    chk({7'h00, irqN_q}, 8'h00, "irq align fail");
    rd(12'h47A, d);
    chk(d, 8'h08, "align fail flag");
    wr(12'h473, 8'h7F);
    rd(12'h47A, d);
    chk(d, 8'h08, "flag kept");
    wr(12'h473, 8'h80);
    rd(12'h47A, d);
    chk(d, 8'h00, "flag cleared");
    chk({7'h00, irqN_q}, 8'h01, "irq cleared");
    wait_sync();
    rd(12'h473, d);
    chk(d, 8'hFF, "status realigned");
    wr(12'h47A, 8'h00);
    $display("test align done");
  endtask : t_align

  task automatic t_sync();
    wr(12'h477, 8'h08);
    dispHit = 8'h01;
    repeat (3) @(negedge clk);
    chk({7'h00, syncRequestOutN_q}, 8'h01, "sync not enabled");
    wr(12'h47B, 8'h80);
    repeat (2) @(negedge clk);
    chk({7'h00, syncRequestOutN_q}, 8'h00, "sync on disparity");
    rd(12'h47B, d);
    chk(d, 8'h80, "sync mask read");
    dispHit = 8'h00;
    wr(12'h47B, 8'hFF);
    rd(12'h47B, d);
    chk(d, 8'hE0, "sync mask bits");
    wait_sync();
    invHit = 8'h01;
    repeat (3) @(negedge clk);
    chk({7'h00, syncRequestOutN_q}, 8'h00, "sync on invalid symbol");
    invHit = 8'h00;
    strayHit = 8'h01;
    repeat (3) @(negedge clk);
    chk({7'h00, syncRequestOutN_q}, 8'h00, "sync on stray control");
    strayHit = 8'h00;
    wr(12'h47B, 8'h00);
    wait_sync();
    $display("test sync done");
  endtask : t_sync

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_config();
    t_flags();
    t_align();
    t_sync();
    complete_run();
  end

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule : slrsi_top_tb
